//--- verilog/host_decode_pkg.sv
// constants for the host legacy decode and pipeline-depth block
// assumes a single 40 MHz system clock domain
package host_decode_pkg;
	localparam logic [7:0] REG_CFG_OFS = 8'h00;
	localparam logic [7:0] REG_ROUTE_OFS = 8'h04;
	localparam int CFG_MDP_BIT = 5;
	localparam int CFG_DEPTH_BIT = 2;
	localparam int CFG_APIC_OFF_BIT = 1;
	localparam int CFG_VGAEN_BIT = 8;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [31:0] MONO_MEM_LO = 32'h000b0000;
	localparam logic [31:0] MONO_MEM_HI = 32'h000b7fff;
	localparam logic [31:0] APIC_LO = 32'hfec00000;
	localparam logic [31:0] APIC_HI = 32'hfec7ffff;
	localparam logic [9:0] VGA_IO_LO = 10'h3bc;
	localparam logic [9:0] VGA_IO_HI = 10'h3bf;
	localparam int IOQ_MAX_DEPTH = 12;
	localparam int IOQ_MIN_DEPTH = 1;
	typedef enum logic [1:0] {DEST_MEM, DEST_HUB, DEST_DEFAULT} dest_t;
endpackage

//--- verilog/strap_sync.sv
// three-flop synchroniser with agreement filter for a pin level
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module strap_sync
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic pinIn,
	output logic levelOut
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			levelOut <= 1'b1;
		end
		else
		begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// change counts only when second and third agree
			if (s2_r == s3_r)
				levelOut <= s3_r;
		end
	end
endmodule // strap_sync

//--- verilog/host_legacy_decode_cfg.sv
// host cycle legacy decode, apic window steering and queue depth strap
// assumes one sys_clk domain; processor reset and strap pin are asynchronous
//
// Behaviour
// - mono present bit and vga enable together steer mono memory and io.
// - with vga enable, io 3bch to 3bfh go to the hub.
// - memory 0b0000h to 0b7fffh is the mono adapter range.
// - mono io ports decoded ignoring address bits 15 to 10.
// - any io reference touching a mono port goes wholly to hub.
// - strap bit 7 captured at processor reset release, read-only depth bit.
// - strap low means queue depth one, no pipelining.
// - strap high or floating means queue depth twelve.
// - in-order queue holds twelve outstanding transactions.
// - address bit 7 stays undriven throughout processor reset.
// - apic disable clear sends fec00000 to fec7ffff to hub.
// - apic disable set leaves apic window to normal decode.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module host_legacy_decode_cfg
#(
	parameter int QUEUE_DEPTH = host_decode_pkg::IOQ_MAX_DEPTH
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic processorResetOut,
	input wire logic hostAddrBit7In,
	output logic hostAddrBit7Out,
	output logic hostAddrBit7Oe,
	input wire logic cycValid,
	input wire logic cycIsIo,
	input wire logic [31:0] cycAddr,
	input wire logic [3:0] cycByteEn,
	input wire logic [1:0] baseDest,
	output logic routeValid,
	output logic [1:0] routeDest,
	input wire logic txnIssue,
	input wire logic txnRetire,
	output logic queueFull,
	output logic [3:0] queueCount,
	output logic [3:0] queueLimit
);
	logic monoPresent_r;
	logic vgaEnable_r;
	logic apicDisable_r;
	logic queueDepth_r;
	logic rstSeen_r;
	logic rstLevel;
	logic strapLevel;
	logic [3:0] count_r;
	logic [3:0] count_nxt;
	logic [3:0] limit_nxt;
	wire cfgHit = regAddr == host_decode_pkg::REG_CFG_OFS;
	wire routeHit = regAddr == host_decode_pkg::REG_ROUTE_OFS;

	strap_sync u_rst_sync
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pinIn(processorResetOut),
		.levelOut(rstLevel)
	);
	strap_sync u_strap_sync
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pinIn(hostAddrBit7In),
		.levelOut(strapLevel)
	);

	// io port match on low ten bits only, so every isa alias hits
	function automatic logic mono_io_hit(input logic [9:0] a);
		return a == 10'h3b4 || a == 10'h3b5 || a == 10'h3b8 || a == 10'h3b9 ||
			a == 10'h3ba || a == 10'h3bf;
	endfunction

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		return a >= lo && a <= hi;
	endfunction

	// byte enables widen the reference; any touched port claims the whole cycle
	wire [9:0] ioBase = {cycAddr[9:2], 2'b00};
	wire ioMonoTouch = (cycByteEn[0] && mono_io_hit(ioBase)) ||
		(cycByteEn[1] && mono_io_hit(ioBase | 10'h001)) ||
		(cycByteEn[2] && mono_io_hit(ioBase | 10'h002)) ||
		(cycByteEn[3] && mono_io_hit(ioBase | 10'h003));
	wire ioVgaTouch = ioBase == host_decode_pkg::VGA_IO_LO && |cycByteEn;
	wire memMono = in_range(cycAddr, host_decode_pkg::MONO_MEM_LO, host_decode_pkg::MONO_MEM_HI);
	wire memApic = in_range(cycAddr, host_decode_pkg::APIC_LO, host_decode_pkg::APIC_HI);
	wire monoRoute = monoPresent_r && vgaEnable_r;
	// mono window only reaches the hub when the graphics path would otherwise claim it
	wire toHub = cycIsIo ? ((monoRoute && ioMonoTouch) || (vgaEnable_r && ioVgaTouch)) :
		((monoRoute && memMono) || (!apicDisable_r && memApic));
	wire [1:0] dest_nxt = toHub ? 2'(host_decode_pkg::DEST_HUB) : baseDest;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			routeValid <= 1'b0;
			routeDest <= 2'(host_decode_pkg::DEST_DEFAULT);
		end
		else
		begin
			routeValid <= cycValid;
			routeDest <= dest_nxt;
		end
	end

	// strap capture: sample once on reset release, hold at all other times
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			queueDepth_r <= 1'b1;
			rstSeen_r <= 1'b1;
		end
		else
		begin
			rstSeen_r <= rstLevel;
			if (rstSeen_r && !rstLevel)
				queueDepth_r <= strapLevel;
		end
	end

	// never drive the strap pin; the board decides the depth
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hostAddrBit7Out <= 1'b0;
			hostAddrBit7Oe <= 1'b0;
		end
		else
		begin
			hostAddrBit7Out <= 1'b0;
			hostAddrBit7Oe <= 1'b0;
		end
	end

	assign limit_nxt = queueDepth_r ? 4'(QUEUE_DEPTH) : 4'(host_decode_pkg::IOQ_MIN_DEPTH);
	wire canIssue = txnIssue && (count_r < limit_nxt);
	wire canRetire = txnRetire && (count_r != 4'h0);
	assign count_nxt = count_r + 4'(canIssue) - 4'(canRetire);

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count_r <= 4'h0;
			queueCount <= 4'h0;
			queueLimit <= 4'(QUEUE_DEPTH);
			queueFull <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			queueCount <= count_nxt;
			queueLimit <= limit_nxt;
			queueFull <= count_nxt >= limit_nxt;
		end
	end

	// software settings; the depth bit ignores writes
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			monoPresent_r <= 1'b0;
			apicDisable_r <= 1'b0;
			vgaEnable_r <= 1'b0;
		end
		else if (regWr && cfgHit)
		begin
			monoPresent_r <= regWdata[host_decode_pkg::CFG_MDP_BIT];
			apicDisable_r <= regWdata[host_decode_pkg::CFG_APIC_OFF_BIT];
		end
		else if (regWr && routeHit)
			vgaEnable_r <= regWdata[host_decode_pkg::CFG_VGAEN_BIT];
	end

	wire [15:0] cfgView = 16'({monoPresent_r, 2'b00, queueDepth_r, apicDisable_r, 1'b0});
	wire [15:0] routeView = 16'({vgaEnable_r, 8'h00});
	wire [15:0] rd_nxt = !regRd ? 16'h0000 : cfgHit ? cfgView : routeHit ? routeView : 16'h0000;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			regRdata <= 16'h0000;
		else
			regRdata <= rd_nxt;
	end

	// checks
	a_apic_hub_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && !cycIsIo && !apicDisable_r && memApic |=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("apic window not sent to hub");
	a_apic_dis_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && !cycIsIo && apicDisable_r && memApic && !memMono |=> routeDest == $past(baseDest))
		else $error("apic window not left to base decode");
	a_mono_mem_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && !cycIsIo && monoPresent_r && vgaEnable_r && memMono
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("mono memory not sent to hub");
	a_mono_io_alias: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && monoRoute && cycAddr[9:0] == 10'h3b4 && cycByteEn[0]
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("mono io alias missed");
	a_mono_needs_vga: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && !vgaEnable_r |=> routeDest == $past(baseDest))
		else $error("io routed to hub without vga enable");
	a_strap_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!rstLevel && !rstSeen_r |=> $stable(queueDepth_r))
		else $error("queue depth changed outside reset");
	a_strap_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rstSeen_r && !rstLevel |=> queueDepth_r == $past(strapLevel))
		else $error("strap not captured on release");
	a_pin_undriven: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rstLevel |-> !hostAddrBit7Oe)
		else $error("strap pin driven in reset");
	a_depth_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!queueDepth_r && count_r == 4'h1 && !txnRetire |=> count_r == 4'h1)
		else $error("pipelining beyond depth one");
	a_depth_max: assert property (@(posedge sys_clk) disable iff (sys_rst)
		count_r <= 4'(QUEUE_DEPTH))
		else $error("queue over twelve");

	// routing: io and memory windows
	a_vga_io_hub: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && vgaEnable_r && cycAddr[9:2] == 8'hef && cycByteEn != 4'h0
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("vga io range not sent to hub");
	a_vga_off_io: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && !vgaEnable_r
		|=> routeDest == $past(baseDest))
		else $error("io claimed with vga enable clear");
	a_mono_io_span: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && monoRoute && cycAddr[9:2] == 8'hee && cycByteEn[2]
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("wide io touching mono port missed");
	a_mono_io_top: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && monoRoute && cycAddr[9:2] == 8'hef && cycByteEn[3]
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("mono port 3bf missed");
	a_mono_io_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && monoRoute && cycAddr[9:2] == 8'hed && cycByteEn[1]
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("mono port 3b5 missed");
	a_mono_io_b9: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && cycIsIo && monoRoute && cycAddr[9:2] == 8'hee && cycByteEn[1]
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("mono port 3b9 missed");
	a_mono_off_mem: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && !cycIsIo && !monoPresent_r && memMono
		|=> routeDest == $past(baseDest))
		else $error("mono memory claimed without present bit");
	a_mono_novga_mem: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && !cycIsIo && !vgaEnable_r && memMono
		|=> routeDest == $past(baseDest))
		else $error("mono memory claimed without vga enable");
	a_apic_low_edge: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid && !cycIsIo && !apicDisable_r && cycAddr == host_decode_pkg::APIC_LO
		|=> routeDest == 2'(host_decode_pkg::DEST_HUB))
		else $error("apic window base not sent to hub");
	a_route_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cycValid
		|=> routeValid)
		else $error("route valid missing");
	a_route_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cycValid
		|=> !routeValid)
		else $error("route valid without cycle");

	// queue depth and occupancy
	a_limit_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!queueDepth_r
		|=> queueLimit == 4'h1)
		else $error("limit not one with strap low");
	a_limit_max: assert property (@(posedge sys_clk) disable iff (sys_rst)
		queueDepth_r
		|=> queueLimit == 4'(QUEUE_DEPTH))
		else $error("limit not maximum with strap high");
	a_full_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
		1'b1
		|-> queueFull == (queueCount >= queueLimit))
		else $error("full flag disagrees with count");
	a_count_mirror: assert property (@(posedge sys_clk) disable iff (sys_rst)
		1'b1
		|-> queueCount == count_r)
		else $error("count output disagrees with queue");
	a_issue_refused: assert property (@(posedge sys_clk) disable iff (sys_rst)
		txnIssue && !txnRetire && count_r >= limit_nxt
		|=> count_r == $past(count_r))
		else $error("issue taken past limit");
	a_issue_taken: assert property (@(posedge sys_clk) disable iff (sys_rst)
		txnIssue && !txnRetire && count_r < limit_nxt
		|=> count_r == $past(count_r) + 4'h1)
		else $error("issue below limit lost");
	a_retire_empty: assert property (@(posedge sys_clk) disable iff (sys_rst)
		txnRetire && !txnIssue && count_r == 4'h0
		|=> count_r == 4'h0)
		else $error("retire from empty queue");

	// strap pin and captured depth
	a_pin_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
		1'b1
		|-> !hostAddrBit7Out)
		else $error("strap pin output not low");
	a_depth_ro: assert property (@(posedge sys_clk) disable iff (sys_rst)
		regWr && cfgHit && !(rstSeen_r && !rstLevel)
		|=> $stable(queueDepth_r))
		else $error("depth bit changed by write");
	a_depth_held: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rstLevel
		|=> $stable(queueDepth_r))
		else $error("depth changed while reset held");

	// register read port
	a_read_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!regRd
		|=> regRdata == 16'h0000)
		else $error("read data without strobe");
	a_cfg_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		regRd && cfgHit
		|=> regRdata == $past(cfgView))
		else $error("config read data wrong");
	a_route_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		regRd && routeHit
		|=> regRdata == $past(routeView))
		else $error("route read data wrong");

	c_full_queue: cover property (@(posedge sys_clk) disable iff (sys_rst) count_r == 4'(QUEUE_DEPTH));
	c_mono_mem_hub: cover property (@(posedge sys_clk) disable iff (sys_rst) cycValid && !cycIsIo && monoRoute && memMono);
	c_depth_one_full: cover property (@(posedge sys_clk) disable iff (sys_rst) !queueDepth_r && queueFull);
	c_hub_io: cover property (@(posedge sys_clk) disable iff (sys_rst) cycValid && cycIsIo && toHub);
	c_strap_low: cover property (@(posedge sys_clk) disable iff (sys_rst) rstSeen_r && !rstLevel && !strapLevel);
endmodule // host_legacy_decode_cfg

//--- tb/host_proc_model.sv
// host processor model: processor reset and address strap pin
// assumes sys_clk from the bench; pin pulled up when undriven
`timescale 1ns/1ps
module host_proc_model
(
	input wire logic sys_clk,
	output logic processorResetOut,
	output logic hostAddrBit7In
);
	initial
	begin
		processorResetOut = 1'b0;
		hostAddrBit7In = 1'b1;
	end
	// pull-up gives 1 whenever the pin is not driven
	task automatic cpu_reset(input logic strapLow);
	begin
		@(posedge sys_clk);
		processorResetOut <= 1'b1;
		hostAddrBit7In <= ~strapLow;
		repeat (8) @(posedge sys_clk);
		processorResetOut <= 1'b0;
		repeat (6) @(posedge sys_clk);
		hostAddrBit7In <= 1'b1;
	end
	endtask
endmodule // host_proc_model

//--- tb/tb.sv
// bench: register access, cycle routing, strap capture, queue depth
// assumes host_proc_model owns processor reset and strap pin
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] CFG = host_decode_pkg::REG_CFG_OFS;
	localparam logic [7:0] RTE = host_decode_pkg::REG_ROUTE_OFS;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdata;
	logic processorResetOut;
	logic hostAddrBit7In;
	logic cycValid = 1'b0;
	logic cycIsIo = 1'b0;
	logic [31:0] cycAddr = 32'h00000000;
	logic [3:0] cycByteEn = 4'h0;
	logic [1:0] baseDest = 2'h0;
	logic routeValid;
	logic [1:0] routeDest;
	logic txnIssue = 1'b0;
	logic txnRetire = 1'b0;
	logic queueFull;
	logic [3:0] queueCount;
	logic [3:0] queueLimit;
	logic hostAddrBit7Out;
	logic hostAddrBit7Oe;
	int error_cnt = 0;
	int checks = 0;
	always #12.5 sys_clk = ~sys_clk;
	host_proc_model u_host (.sys_clk, .processorResetOut, .hostAddrBit7In);
	host_legacy_decode_cfg u_dut
	(
		.sys_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.processorResetOut, .hostAddrBit7In, .hostAddrBit7Out, .hostAddrBit7Oe,
		.cycValid, .cycIsIo, .cycAddr, .cycByteEn, .baseDest, .routeValid,
		.routeDest, .txnIssue, .txnRetire, .queueFull, .queueCount, .queueLimit
	);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
	begin
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	end
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
	begin
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk(regRdata, exp);
	end
	endtask
	task automatic rt(input logic io, input logic [31:0] a, input logic [3:0] be, input logic [1:0] exp);
	begin
		@(posedge sys_clk);
		cycValid <= 1'b1;
		cycIsIo <= io;
		cycAddr <= a;
		cycByteEn <= be;
		@(posedge sys_clk);
		cycValid <= 1'b0;
		#1 chk({15'h0, routeValid}, 16'h1);
		chk({14'h0, routeDest}, {14'h0, exp});
	end
	endtask
	task automatic pulse(input int n, input logic retire);
	begin
		@(posedge sys_clk);
		if (retire)
			txnRetire <= 1'b1;
		else
			txnIssue <= 1'b1;
		repeat (n) @(posedge sys_clk);
		txnIssue <= 1'b0;
		txnRetire <= 1'b0;
		#1;
	end
	endtask
	task automatic conclude;
	begin
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	initial
	begin
		#50us;
		error_cnt++;
		conclude();
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(CFG, 16'h0004);
		rd(8'h08, 16'h0000);
		wr(RTE, 16'h0100);
		rd(RTE, 16'h0100);
		wr(CFG, 16'hffff);
		rd(CFG, 16'h0026);
		$display("test regs done");
		rt(1'b0, 32'h000b0000, 4'hf, 2'h1);
		rt(1'b0, 32'h000b7ffc, 4'hf, 2'h1);
		rt(1'b0, 32'h000b8000, 4'hf, 2'h0);
		rt(1'b1, 32'h0000ffb4, 4'h1, 2'h1);
		rt(1'b1, 32'h000003b4, 4'h4, 2'h0);
		rt(1'b1, 32'h000003b8, 4'hc, 2'h1);
		rt(1'b0, 32'hfec00000, 4'hf, 2'h0);
		wr(CFG, 16'h0000);
		rt(1'b0, 32'h000b0000, 4'hf, 2'h0);
		rt(1'b0, 32'hfec7fffc, 4'hf, 2'h1);
		rt(1'b0, 32'hfec80000, 4'hf, 2'h0);
		rt(1'b1, 32'h000003bc, 4'h1, 2'h1);
		wr(RTE, 16'h0000);
		rt(1'b1, 32'h000003bc, 4'h1, 2'h0);
		$display("test routing done");
		fork
			u_host.cpu_reset(1'b1);
			#100 chk({15'h0, hostAddrBit7Oe}, 16'h0);
		join
		chk({15'h0, hostAddrBit7Out}, 16'h0);
		repeat (10) @(posedge sys_clk);
		rd(CFG, 16'h0000);
		chk({12'h0, queueLimit}, 16'h1);
		pulse(2, 1'b0);
		chk({12'h0, queueCount}, 16'h1);
		chk({15'h0, queueFull}, 16'h1);
		repeat (10) @(posedge sys_clk);
		rd(CFG, 16'h0000);
		pulse(1, 1'b1);
		chk({12'h0, queueCount}, 16'h0);
		u_host.cpu_reset(1'b0);
		repeat (10) @(posedge sys_clk);
		rd(CFG, 16'h0004);
		chk({12'h0, queueLimit}, 16'(host_decode_pkg::IOQ_MAX_DEPTH));
		pulse(13, 1'b0);
		chk({12'h0, queueCount}, 16'(host_decode_pkg::IOQ_MAX_DEPTH));
		chk({15'h0, queueFull}, 16'h1);
		$display("test strap queue done");
		conclude();
	end
endmodule // tb
